// ===== can_rx_fifo_pkg.sv
// constants, types and register map of the receive fifo with id filter
package can_rx_fifo_pkg;
	localparam int ADDR_W = 10;
	// register byte offsets
	localparam logic [9:0] OFF_CTRL = 10'h000;
	localparam logic [9:0] OFF_STAT = 10'h004;
	localparam logic [9:0] OFF_OUT_INFO = 10'h080;
	localparam logic [9:0] OFF_OUT_ID = 10'h084;
	localparam logic [9:0] OFF_OUT_DLO = 10'h088;
	localparam logic [9:0] OFF_OUT_DHI = 10'h08c;
	localparam logic [9:0] OFF_FILT_BASE = 10'h0e0;
	localparam int FILT_FIRST_NUM = 4;
	localparam logic [7:0] FILT_MAX = 8'h68;
	// main control register fields
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_FS_LSB = 8;
	localparam int CTL_CNT_LSB = 16;
	localparam logic [1:0] FS_A = 2'h0;
	// status register fields
	localparam int STAT_AVAIL_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_CNT_LSB = 8;
	// output and filter word fields
	localparam int IDX_LSB = 23;
	localparam int IDE_BIT = 21;
	localparam int RTR_BIT = 20;
	localparam int DLC_LSB = 16;
	localparam int STD_LSB = 18;
	localparam int FILT_RTR_BIT = 31;
	localparam int FILT_IDE_BIT = 30;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam logic [2:0] FIFO_DEPTH = 3'h6;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_STORE = 2'b11
	} scan_state_t;

	// frame as delivered by the protocol engine; standard id sits in 28:18
	typedef struct packed {
		logic fdf;
		logic ide;
		logic rtr;
		logic [3:0] dlc;
		logic [28:0] id;
		logic [63:0] data;
	} rx_frame_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [9:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [8:0] idx;
		rx_frame_t frame;
	} fifo_entry_t;
endpackage

// ===== can_rx_fifo.sv
// receive fifo output words and format a identifier filter table
`timescale 1ns/10ps
module can_rx_fifo (
	input wire logic clk,
	input wire logic rst_b,
	input wire can_rx_fifo_pkg::bus_req_t bus_req,
	output logic [31:0] rdata_q,
	input wire logic rx_valid,
	input wire can_rx_fifo_pkg::rx_frame_t rx_frame,
	output logic fifo_avail_q
);
	logic [31:0] ctrl_q;
	logic [31:0] filt [0:103];
	can_rx_fifo_pkg::fifo_entry_t mem [0:5];
	logic [2:0] wr_ptr_q;
	logic [2:0] rd_ptr_q;
	logic [2:0] count_q;
	logic ovf_q;
	can_rx_fifo_pkg::scan_state_t state_q;
	can_rx_fifo_pkg::rx_frame_t cand_q;
	logic [6:0] scan_q;
	logic [8:0] match_q;

	function automatic logic [2:0] next_ptr(input logic [2:0] p);
		next_ptr = (p == can_rx_fifo_pkg::FIFO_DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
	endfunction

	// element position from a byte address; unaligned or past the end misses
	function automatic logic [7:0] filt_sel(input logic [9:0] a);
		logic [9:0] off;
		off = a - can_rx_fifo_pkg::OFF_FILT_BASE;
		filt_sel = 8'hff;
		if (a >= can_rx_fifo_pkg::OFF_FILT_BASE && off[1:0] == 2'h0 &&
			off[9:2] < can_rx_fifo_pkg::FILT_MAX) begin
			filt_sel = {1'b0, off[8:2]};
		end
	endfunction

	// format a compare of one element against the candidate frame
	function automatic logic elem_hit(input logic [31:0] e,
		input can_rx_fifo_pkg::rx_frame_t f);
		logic id_ok;
		id_ok = 1'b0;
		if (e[can_rx_fifo_pkg::FILT_IDE_BIT]) begin
			id_ok = (e[28:0] == f.id);
		end else begin
			id_ok = (e[28:18] == f.id[28:18]);
		end
		elem_hit = id_ok &&
			(e[can_rx_fifo_pkg::FILT_RTR_BIT] == f.rtr) &&
			(e[can_rx_fifo_pkg::FILT_IDE_BIT] == f.ide);
	endfunction

	// bytes past the length code are cleared so stale bytes never show
	function automatic logic [63:0] mask_data(input logic [63:0] d,
		input logic [3:0] dlc);
		logic [63:0] m;
		m = d;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) >= dlc) begin
				m[63 - 8 * i -: 8] = 8'h00;
			end
		end
		mask_data = m;
	endfunction

	// control fields
	wire logic enable = ctrl_q[can_rx_fifo_pkg::CTL_ENABLE_BIT];
	wire logic [1:0] fmt_sel = ctrl_q[can_rx_fifo_pkg::CTL_FS_LSB +: 2];
	wire logic [3:0] cnt_field = ctrl_q[can_rx_fifo_pkg::CTL_CNT_LSB +: 4];
	wire logic [4:0] cnt_plus = {1'b0, cnt_field} + 5'h1;
	wire logic [7:0] raw_limit = {cnt_plus, 3'h0};
	// table size is 8*(field+1) elements, capped at 104, so 8 after reset
	wire logic [7:0] limit = (raw_limit > can_rx_fifo_pkg::FILT_MAX) ?
		can_rx_fifo_pkg::FILT_MAX : raw_limit;
	// only format a is decoded; other formats match nothing, so a frame
	// is never judged by a half-understood layout
	wire logic fmt_a = (fmt_sel == can_rx_fifo_pkg::FS_A);

	// bus decode
	wire logic [7:0] wr_filt = filt_sel(bus_req.addr);
	wire logic wr_filt_hit = bus_req.wr && !wr_filt[7];
	wire logic wr_ctrl = bus_req.wr &&
		bus_req.addr == can_rx_fifo_pkg::OFF_CTRL;
	wire logic wr_stat = bus_req.wr &&
		bus_req.addr == can_rx_fifo_pkg::OFF_STAT;
	wire logic release_req = wr_stat &&
		bus_req.wdata[can_rx_fifo_pkg::STAT_AVAIL_BIT];
	wire logic ovf_clr = wr_stat &&
		bus_req.wdata[can_rx_fifo_pkg::STAT_OVF_BIT];

	// fifo bookkeeping
	wire logic empty = (count_q == 3'h0);
	wire logic full = (count_q == can_rx_fifo_pkg::FIFO_DEPTH);
	wire logic push = (state_q == can_rx_fifo_pkg::ST_STORE) && !full;
	wire logic pop = release_req && !empty;
	wire logic lost = (rx_valid && state_q != can_rx_fifo_pkg::ST_IDLE) ||
		((state_q == can_rx_fifo_pkg::ST_STORE) && full);
	wire logic [2:0] count_d = count_q + {2'h0, push} - {2'h0, pop};
	wire logic take = rx_valid && enable && !rx_frame.fdf &&
		state_q == can_rx_fifo_pkg::ST_IDLE;
	wire logic hit_now = fmt_a && elem_hit(filt[scan_q], cand_q);
	wire logic scan_last = ({1'b0, scan_q} == limit - 8'h1);

	// oldest unread entry drives the output words
	wire can_rx_fifo_pkg::fifo_entry_t head = mem[rd_ptr_q];
	wire logic [31:0] out_info = empty ? 32'h0 :
		{head.idx, 1'b0, head.frame.ide, head.frame.rtr,
		head.frame.dlc, 16'h0000};
	wire logic [17:0] ext_part = head.frame.ide ?
		head.frame.id[17:0] : 18'h0;
	wire logic [31:0] out_id = empty ? 32'h0 :
		{3'h0, head.frame.id[28:18], ext_part};
	wire logic [31:0] out_dlo = empty ? 32'h0 :
		head.frame.data[63:32];
	wire logic [31:0] out_dhi = empty ? 32'h0 :
		head.frame.data[31:0];
	wire logic [31:0] stat_word = {20'h0, 1'b0, count_q, 6'h0, ovf_q, !empty};
	wire logic [7:0] rd_filt = filt_sel(bus_req.addr);
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0;
		if (!rd_filt[7]) begin
			rd_word = filt[rd_filt[6:0]];
		end else begin
			unique case (bus_req.addr)
				can_rx_fifo_pkg::OFF_CTRL: rd_word = ctrl_q;
				can_rx_fifo_pkg::OFF_STAT: rd_word = stat_word;
				can_rx_fifo_pkg::OFF_OUT_INFO: rd_word = out_info;
				can_rx_fifo_pkg::OFF_OUT_ID: rd_word = out_id;
				can_rx_fifo_pkg::OFF_OUT_DLO: rd_word = out_dlo;
				can_rx_fifo_pkg::OFF_OUT_DHI: rd_word = out_dhi;
				default: rd_word = 32'h0;
			endcase
		end
	end

	// read data stands for exactly the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= bus_req.rd ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_q <= can_rx_fifo_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= bus_req.wdata;
		end
	end

	// filter table is plain memory, contents undefined until written
	always_ff @(posedge clk) begin
		if (wr_filt_hit) begin
			filt[wr_filt[6:0]] <= bus_req.wdata;
		end
	end

	// a loss in the same cycle as the clear keeps the flag set
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= lost | (ovf_q & ~ovf_clr);
		end
	end

	// one element is examined per cycle; the lowest index that matches wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= can_rx_fifo_pkg::ST_IDLE;
			cand_q <= '0;
			scan_q <= 7'h0;
			match_q <= 9'h0;
		end else begin
			unique case (state_q)
				can_rx_fifo_pkg::ST_IDLE: begin
					if (take) begin
						cand_q <= rx_frame;
						cand_q.data <= mask_data(rx_frame.data, rx_frame.dlc);
						scan_q <= 7'h0;
						state_q <= can_rx_fifo_pkg::ST_SCAN;
					end
				end
				can_rx_fifo_pkg::ST_SCAN: begin
					if (hit_now) begin
						match_q <= {2'h0, scan_q};
						state_q <= can_rx_fifo_pkg::ST_STORE;
					end else if (scan_last) begin
						state_q <= can_rx_fifo_pkg::ST_IDLE;
					end else begin
						scan_q <= scan_q + 7'h1;
					end
				end
				can_rx_fifo_pkg::ST_STORE: begin
					state_q <= can_rx_fifo_pkg::ST_IDLE;
				end
				default: begin
					state_q <= can_rx_fifo_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= '{idx: match_q, frame: cand_q};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_ptr_q <= 3'h0;
			rd_ptr_q <= 3'h0;
			count_q <= 3'h0;
			fifo_avail_q <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= next_ptr(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= next_ptr(rd_ptr_q);
			end
			count_q <= count_d;
			fifo_avail_q <= (count_d != 3'h0);
		end
	end
endmodule

// ===== can_rx_fifo_checker.sv
// port assertions for the receive fifo with id filter
`timescale 1ns/10ps
module can_rx_fifo_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire can_rx_fifo_pkg::bus_req_t bus_req,
	input wire logic [31:0] rdata_q,
	input wire logic rx_valid,
	input wire can_rx_fifo_pkg::rx_frame_t rx_frame,
	input wire logic fifo_avail_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] since_q;
	logic fd_q;
	wire rel = bus_req.wr && bus_req.addr == 10'h004 && bus_req.wdata[0];
	// saturates so an old frame can never explain a new entry
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			since_q <= 8'hff;
			fd_q <= 1'b0;
		end else if (rx_valid) begin
			since_q <= 8'h00;
			fd_q <= rx_frame.fdf;
		end else if (since_q != 8'hff) begin
			since_q <= since_q + 8'h01;
		end
	end
	sequence empty_rd(logic [9:0] a);
		!fifo_avail_q && bus_req.rd && bus_req.addr == a;
	endsequence
	a_id_top_zero: assert property (
		bus_req.rd && bus_req.addr == 10'h084 |=> rdata_q[31:29] == 3'h0)
		else $error("id word top bits not zero");
	a_empty_id_zero: assert property (
		empty_rd(10'h084) |=> rdata_q == 32'h0)
		else $error("id word not zero while empty");
	a_empty_data_zero: assert property (
		empty_rd(10'h088) |=> rdata_q == 32'h0)
		else $error("data word not zero while empty");
	a_avail_holds: assert property (
		fifo_avail_q && !rel |=> fifo_avail_q)
		else $error("entry vanished without release");
	a_avail_release: assert property (
		$fell(fifo_avail_q) |-> $past(rel))
		else $error("fifo emptied without release");
	a_store_after_frame: assert property (
		$rose(fifo_avail_q) |-> since_q inside {[8'h02:8'h78]})
		else $error("entry stored without a recent frame");
	a_no_fd_store: assert property (
		$rose(fifo_avail_q) |-> !fd_q)
		else $error("fd frame stored");
	a_rdata_one_cycle: assert property (
		rdata_q != 32'h0 |-> $past(bus_req.rd))
		else $error("read data outside read cycle");
endmodule
bind can_rx_fifo can_rx_fifo_checker can_rx_fifo_checker_inst (
	.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata_q(rdata_q),
	.rx_valid(rx_valid), .rx_frame(rx_frame), .fifo_avail_q(fifo_avail_q));

// ===== can_node_model.sv
// remote node model: hands received frames to the fifo one pulse each
`timescale 1ns/10ps
module can_node_model (
	input wire logic clk,
	output logic rx_valid,
	output can_rx_fifo_pkg::rx_frame_t rx_frame
);
	initial begin
		rx_valid = 1'b0;
		rx_frame = '0;
	end
	task automatic send(input can_rx_fifo_pkg::rx_frame_t f);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_frame <= f;
		@(posedge clk);
		rx_valid <= 1'b0;
		// stale lines flip so a late sample cannot pass for the frame
		rx_frame <= ~f;
		// the scanner drops frames while busy, so wait out an eight-element table
		repeat (12) @(posedge clk);
	endtask
endmodule

// ===== can_rx_fifo_tb.sv
// self-checking bench for the receive fifo with id filter
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module can_rx_fifo_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	can_rx_fifo_pkg::bus_req_t req = '0;
	logic [31:0] rdata_q;
	logic rx_valid;
	can_rx_fifo_pkg::rx_frame_t rx_frame;
	logic fifo_avail_q;
	int error_cnt = 0;
	int compares = 0;
	always #5 clk = ~clk;
	can_rx_fifo can_rx_fifo_inst (.clk(clk), .rst_b(rst_b), .bus_req(req),
		.rdata_q(rdata_q), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.fifo_avail_q(fifo_avail_q));
	can_node_model can_node_model_inst (.clk(clk), .rx_valid(rx_valid),
		.rx_frame(rx_frame));
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 `CHK($sformatf("addr %h", a), e, rdata_q)
	endtask
	task automatic frame(input logic f, input logic x, input logic r,
		input logic [3:0] n, input logic [28:0] id);
		can_node_model_inst.send('{f, x, r, n, id, 64'h0102030405060708});
	endtask
	task automatic entry(input logic [31:0] inf, input logic [31:0] id,
		input logic [31:0] lo, input logic [31:0] hi);
		rd(10'h080, inf);
		rd(10'h084, id);
		rd(10'h088, lo);
		rd(10'h08c, hi);
		wr(10'h004, 32'h1);
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd(10'h000, 32'h0);
		wr(10'h000, 32'h1);
		wr(10'h0e0, 32'h048c0000);
		wr(10'h0e4, 32'hd2345678);
		for (int i = 2; i < 7; i++)
			wr(10'h0e0 + 10'(4 * i), 32'h0);
		wr(10'h0fc, 32'h9ffc0000);
		wr(10'h100, 32'h01540000);
		rd(10'h0e4, 32'hd2345678);
		frame(1'b1, 1'b0, 1'b0, 4'h6, 29'h048c0000);
		frame(1'b0, 1'b0, 1'b0, 4'h6, 29'h048c0000);
		frame(1'b0, 1'b0, 1'b1, 4'h0, 29'h048c0000);
		frame(1'b0, 1'b1, 1'b0, 4'h8, 29'h048c0000);
		frame(1'b0, 1'b1, 1'b1, 4'h0, 29'h12345678);
		frame(1'b0, 1'b0, 1'b0, 4'h8, 29'h01540000);
		frame(1'b0, 1'b0, 1'b1, 4'h0, 29'h1ffc0000);
		#1 `CHK("avail", 1'b1, fifo_avail_q)
		rd(10'h004, 32'h00000301);
		entry(32'h00060000, 32'h048c0000, 32'h01020304, 32'h05060000);
		entry(32'h00b00000, 32'h12345678, 32'h0, 32'h0);
		entry(32'h03900000, 32'h1ffc0000, 32'h0, 32'h0);
		rd(10'h084, 32'h0);
		rd(10'h004, 32'h0);
		#1 `CHK("avail", 1'b0, fifo_avail_q)
		wr(10'h000, 32'h101);
		frame(1'b0, 1'b0, 1'b0, 4'h6, 29'h048c0000);
		rd(10'h088, 32'h0);
		end_sim();
	end
endmodule
